// [design/alu_flag_unit.sv]
// alu with zero, digit carry and carry results
`timescale 1ns/1ps
module alu_flag_unit (
	input  wire status_pkg::alu_op_e op_i,      // operation
	input  wire logic [7:0]          a_i,       // file or literal operand
	input  wire logic [7:0]          b_i,       // working register operand
	output logic [7:0]               result_o,  // result byte
	output logic                     zero_o,    // result is zero
	output logic                     digit_o,   // carry out of bit 3
	output logic                     carry_o,   // carry out of bit 7
	output logic                     arith_o,   // op sets digit and carry
	output logic                     logic_o    // op sets zero
);
	import status_pkg::*;
	logic [4:0] low_sum;  // nibble sum with carry out
	logic [8:0] full_sum; // byte sum with carry out
	logic [7:0] addend;   // b or its two's complement
	// --------------------------------------------------------
	// arithmetic and flag derivation
	// --------------------------------------------------------
	always_comb begin
		// subtraction adds the two's complement of b
		addend   = (op_i == op_sub) ? 8'(~b_i + 8'h01) : b_i;
		low_sum  = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]};
		full_sum = {1'b0, a_i} + {1'b0, addend};
		// on subtract, carry out of the sum is the inverted borrow
		// a zero subtrahend adds zero and would clear carry, yet no borrow occurs
		digit_o  = low_sum[4] | ((op_i == op_sub) && (b_i[3:0] == 4'h0));
		carry_o  = full_sum[8] | ((op_i == op_sub) && (b_i == 8'h00));
		unique case (op_i)
			op_add, op_sub: result_o = full_sum[7:0];
			op_and:         result_o = a_i & b_i;
			op_or:          result_o = a_i | b_i;
			op_xor:         result_o = a_i ^ b_i;
			op_clr:         result_o = 8'h00;
			default:        result_o = a_i; // pass
		endcase
		zero_o  = (result_o == 8'h00);
		arith_o = (op_i == op_add) || (op_i == op_sub);
		logic_o = (op_i != op_pass);
	end
endmodule

// [design/alu_status_bank_select.sv]
// core status word, bank select, upper pc holding and prescaler assignment
// Notes on behaviour
// - flag-setting writes ignore written z dc c
// - timeout and power-down bits are read-only
// - clear-file on status clears top three, sets zero
// - bank select picks bank for direct addresses
// - subtract carry and digit are inverted borrows
// - subtract adds two's complement of operand
// - status decodes at 03h and 83h alike
// - upper pc only through holding register
// - unimplemented holding-register bits read zero; unmapped locations read the general file
// - power-on: bank zero, cause bits one
// - prescaler goes to timer or watchdog only
// - timer counts 1:1 when prescaler on watchdog
// - any instruction may target status word
`timescale 1ns/1ps
module alu_status_bank_select (
	input  wire logic                clk_sys_i,       // core clock
	input  wire logic                nrst_i,          // power-on reset, active low
	input  wire logic                exec_i,          // instruction executes this cycle
	input  wire status_pkg::alu_op_e op_i,            // alu operation
	input  wire logic [6:0]          file_addr_i,     // direct file address
	input  wire logic [7:0]          w_i,             // working register
	input  wire logic [7:0]          file_rd_i,       // data from the general file
	input  wire logic                literal_i,       // a operand is the literal
	input  wire logic [7:0]          literal_val_i,   // literal value
	input  wire logic                dest_file_i,     // result written to the file
	input  wire logic                branch_i,        // branch loads the pc
	input  wire logic                sleep_i,         // sleep instruction
	input  wire logic                wdt_clear_i,     // watchdog clear instruction
	input  wire logic                wdt_timeout_i,   // watchdog expired
	output logic [7:0]               result_o,        // alu result
	output logic [7:0]               read_data_o,     // data of the addressed location
	output logic [8:0]               bank_addr_o,     // banked direct address
	output logic                     write_file_o,    // write result to general file
	output logic [7:0]               status_o,        // status word
	output logic [12:0]              pc_o,            // program counter
	output logic                     timer_prescaled_o, // timer uses the prescaler
	output logic                     wdt_prescaled_o    // watchdog uses the prescaler
);
	import status_pkg::*;
	// --------------------------------------------------------
	// state
	// --------------------------------------------------------
	typedef struct packed {
		logic [7:0]  status;    // status word
		logic [4:0]  pch_hold;  // upper pc holding register
		logic [12:0] pc;        // program counter
		logic [7:0]  option;    // option word
		logic [7:0]  result;    // registered alu result
		logic [7:0]  rdata;     // registered read data
		logic [8:0]  baddr;     // registered banked address
		logic        wfile;     // registered general write
		logic        tmr_ps;    // registered timer prescaler use
	} state_s;
	state_s st;       // current state
	state_s next_st;  // next state
	logic [7:0] a_op;     // first alu operand
	logic [7:0] alu_res;  // alu result
	logic       alu_z;    // zero result
	logic       alu_dc;   // digit carry result
	logic       alu_c;    // carry result
	logic       alu_ar;   // op sets dc and c
	logic       alu_lg;   // op sets z
	logic [7:0] full_addr; // bank bit joined to file address
	logic       hit_status; // status addressed in either bank
	// --------------------------------------------------------
	// alu
	// --------------------------------------------------------
	assign a_op = literal_i ? literal_val_i : read_data_o;
	alu_flag_unit u_alu (
		.op_i     (op_i),
		.a_i      (a_op),
		.b_i      (w_i),
		.result_o (alu_res),
		.zero_o   (alu_z),
		.digit_o  (alu_dc),
		.carry_o  (alu_c),
		.arith_o  (alu_ar),
		.logic_o  (alu_lg)
	);
	// --------------------------------------------------------
	// address decode
	// --------------------------------------------------------
	// low bank bit extends the file address; bit 7:6 are held clear by software
	assign full_addr  = {st.status[st_bank_low], file_addr_i};
	// status is mirrored, so the bank bit is ignored here
	assign hit_status = (file_addr_i == (status_offset[6:0] & mirror_mask));
	// --------------------------------------------------------
	// next state
	// --------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.baddr = {1'b0, full_addr}; // direct bank choice
		next_st.wfile = 1'b0;
		// read mux; unmapped core locations fall to the general file
		if (hit_status) begin
			next_st.rdata = st.status;
		end else if (file_addr_i == pcl_offset[6:0]) begin
			next_st.rdata = st.pc[7:0];
		end else if (file_addr_i == pch_hold_offset[6:0]) begin
			next_st.rdata = {3'h0, st.pch_hold}; // unimplemented bits read zero
		end else if (full_addr == option_offset) begin
			next_st.rdata = st.option;
		end else begin
			next_st.rdata = file_rd_i;
		end
		// free-running pc advance
		next_st.pc = 13'(st.pc + 13'h0001);
		if (exec_i) begin
			next_st.result = alu_res;
			// any instruction may write the status word
			if (dest_file_i && hit_status) begin
				next_st.status[st_indirect]  = alu_res[st_indirect];
				next_st.status[st_bank_high] = alu_res[st_bank_high];
				next_st.status[st_bank_low]  = alu_res[st_bank_low];
				// cause bits are never written here
				// a flag-setting op blocks the write of all three flags
				if (!alu_lg) begin
					next_st.status[st_zero]  = alu_res[st_zero];
					next_st.status[st_digit] = alu_res[st_digit];
					next_st.status[st_carry] = alu_res[st_carry];
				end
			end else if (dest_file_i && (file_addr_i == pch_hold_offset[6:0])) begin
				next_st.pch_hold = alu_res[4:0]; // upper bits dropped
			end else if (dest_file_i && (file_addr_i == pcl_offset[6:0])) begin
				next_st.pc = {st.pch_hold, alu_res};
			end else if (dest_file_i && (full_addr == option_offset)) begin
				next_st.option = alu_res;
			end else begin
				next_st.wfile = dest_file_i;
			end
			// flag results override the written values
			if (alu_lg) begin
				next_st.status[st_zero] = alu_z;
			end
			if (alu_ar) begin
				next_st.status[st_digit] = alu_dc;
				next_st.status[st_carry] = alu_c;
			end
			// branch target takes its upper bits from the holding register
			if (branch_i) begin
				next_st.pc = {st.pch_hold, alu_res};
			end
		end
		// cause bits move only by sleep and watchdog events
		if (sleep_i) begin
			next_st.status[st_power_down] = 1'b0;
			next_st.status[st_timeout]    = 1'b1;
		end
		if (wdt_clear_i) begin
			next_st.status[st_power_down] = 1'b1;
			next_st.status[st_timeout]    = 1'b1;
		end
		if (wdt_timeout_i) begin
			next_st.status[st_timeout] = 1'b0; // timeout wins over clear
		end
		// timer runs 1:1 while the watchdog owns the prescaler
		next_st.tmr_ps = ~next_st.option[opt_assign_wdt];
	end
	// --------------------------------------------------------
	// state register
	// --------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			// power-on values
			st                       <= '0;
			st.status[st_indirect:st_bank_low] <= bank_reset;
			st.status[st_timeout]              <= cause_reset;
			st.status[st_power_down]           <= cause_reset;
			st.status[st_zero:st_carry]        <= flags_reset;
			st.pch_hold                        <= pch_hold_reset;
			st.option                          <= option_reset;
			st.tmr_ps                          <= ~option_reset[opt_assign_wdt];
		end else begin
			st <= next_st;
		end
	end
	// --------------------------------------------------------
	// outputs
	// --------------------------------------------------------
	assign result_o     = st.result;
	assign read_data_o  = st.rdata;
	assign bank_addr_o  = st.baddr;
	assign write_file_o = st.wfile;
	assign status_o     = st.status;
	assign pc_o         = st.pc;
	// prescaler goes to exactly one user; timer runs 1:1 while the watchdog has it
	assign timer_prescaled_o = st.tmr_ps;
	assign wdt_prescaled_o   = st.option[opt_assign_wdt];
	// --------------------------------------------------------
	// checks
	// --------------------------------------------------------
	cause_ro_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(exec_i && dest_file_i && hit_status && !sleep_i && !wdt_clear_i && !wdt_timeout_i)
		|=> $stable(status_o[4:3]))
		else $error("cause bits changed by write");
	clr_status_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(exec_i && op_i == op_clr && dest_file_i && hit_status)
		|=> (status_o[7:5] == 3'h0) && status_o[st_zero])
		else $error("clear of status wrong");
	flag_over_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(exec_i && alu_ar && dest_file_i && hit_status)
		|=> (status_o[1:0] == {$past(alu_dc), $past(alu_c)}))
		else $error("written flags not overridden");
	presc_one_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		timer_prescaled_o != wdt_prescaled_o)
		else $error("prescaler shared");
	sleep_pd_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(sleep_i && !wdt_clear_i) |=> !status_o[st_power_down])
		else $error("sleep did not clear power-down");
	wdt_to_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		wdt_timeout_i |=> !status_o[st_timeout])
		else $error("timeout flag not cleared");
	branch_pc_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(exec_i && branch_i) |=> (pc_o[12:8] == $past(st.pch_hold)))
		else $error("pc upper bits not from holding");
	bank_addr_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		1'b1 |=> (bank_addr_o[7] == $past(status_o[st_bank_low])))
		else $error("bank bit not applied");
	mirror_rd_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		hit_status |=> (read_data_o == $past(status_o)))
		else $error("status mirror read wrong");
endmodule

// [design/status_pkg.sv]
// constants for the core status word and its neighbours
package status_pkg;
	// data memory decode
	localparam logic [7:0] status_offset    = 8'h03; // status word, bank 0 view
	localparam logic [7:0] status_mirror    = 8'h83; // status word, bank 1 view
	localparam logic [7:0] pcl_offset       = 8'h02; // program counter low byte
	localparam logic [7:0] pch_hold_offset  = 8'h0a; // upper pc holding register
	localparam logic [7:0] option_offset    = 8'h81; // option word, bank 1 only
	localparam logic [6:0] mirror_mask      = 7'h7f; // low seven address bits
	localparam int         bank_sel_bit     = 7;     // address bit chosen by bank select
	// status field positions
	localparam int st_carry      = 0;
	localparam int st_digit      = 1;
	localparam int st_zero       = 2;
	localparam int st_power_down = 3;
	localparam int st_timeout    = 4;
	localparam int st_bank_low   = 5;
	localparam int st_bank_high  = 6;
	localparam int st_indirect   = 7;
	// reset values
	localparam logic [2:0] bank_reset       = 3'h0;
	localparam logic       cause_reset      = 1'h1;
	localparam logic [2:0] flags_reset      = 3'h0; // flags cleared at power-on
	localparam logic [4:0] pch_hold_reset   = 5'h00;
	localparam logic [7:0] option_reset     = 8'hff;
	// option word fields
	localparam int opt_assign_wdt = 3;
	localparam int opt_rate_msb   = 2;
	// alu operations
	typedef enum logic [2:0] {
		op_pass = 3'b000, // move, no flags
		op_add  = 3'b001, // add, sets z dc c
		op_sub  = 3'b010, // subtract, sets z dc c
		op_and  = 3'b011, // logic, sets z
		op_or   = 3'b100,
		op_xor  = 3'b101,
		op_clr  = 3'b110  // clear file, sets z
	} alu_op_e;
endpackage

// [dv/alu_status_bank_select_tb.sv]
// self-checking bench for the status word block
`timescale 1ns/1ps
module alu_status_bank_select_tb;
	import status_pkg::*;
	logic        clk_sys_i = 1'b0; // core clock
	logic        nrst_i = 1'b0;    // reset, active low
	logic        exec = 1'b0;      // instruction strobe
	alu_op_e     op_v = op_pass;   // operation
	logic [6:0]  addr = 7'h00;     // direct address
	logic [7:0]  w_v = 8'h00;      // working register
	logic [7:0]  lit_v = 8'h00;    // literal
	logic        lit = 1'b0;       // literal operand select
	logic        dest = 1'b0;      // result to file
	logic        br = 1'b0;        // branch loads the pc
	logic [2:0]  evt = 3'h0;       // sleep, watchdog clear, watchdog timeout
	logic [7:0]  file_rd, result, rdata, status;
	logic [8:0]  baddr;
	logic [12:0] pc;
	logic        wr, tmr_ps, wdt_ps;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cycles = 0;

	alu_status_bank_select i_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .exec_i(exec),
		.op_i(op_v), .file_addr_i(addr), .w_i(w_v), .file_rd_i(file_rd), .literal_i(lit),
		.literal_val_i(lit_v), .dest_file_i(dest), .branch_i(br), .sleep_i(evt[2]),
		.wdt_clear_i(evt[1]), .wdt_timeout_i(evt[0]), .result_o(result),
		.read_data_o(rdata), .bank_addr_o(baddr), .write_file_o(wr), .status_o(status),
		.pc_o(pc), .timer_prescaled_o(tmr_ps), .wdt_prescaled_o(wdt_ps));
	file_ram_model i_ram (.clk_sys_i(clk_sys_i), .file_addr_i(addr), .bank_i(status[5]),
		.bank_addr_i(baddr), .write_i(wr), .data_i(result), .rd_o(file_rd));

	// -----------------------------------------
	// clock, timeout and shared tasks
	// -----------------------------------------
	always #2.5 clk_sys_i = ~clk_sys_i;
	// cut a hang short
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 1000) begin
			error_cnt++;
			results();
		end
	end
	// compare and count
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			error_cnt++;
		end
	endtask
	// address one cycle ahead, then one executing cycle
	task automatic instr(input alu_op_e op, input logic [6:0] a, input logic [7:0] lv,
		input logic [7:0] w, input logic l, input logic d);
		op_v = op;
		addr = a;
		lit_v = lv;
		w_v = w;
		lit = l;
		dest = d;
		@(negedge clk_sys_i);
		exec = 1'b1;
		@(negedge clk_sys_i);
		exec = 1'b0;
	endtask
	// move a byte to a file location; bits 7:6 of status kept clear
	task automatic mov(input logic [6:0] a, input logic [7:0] v);
		instr(op_pass, a, v, v, 1'b1, 1'b1);
	endtask
	// one literal alu operation and its flags
	task automatic alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] res, input logic [2:0] fl);
		instr(op, 7'h00, a, b, 1'b1, 1'b0);
		check("result", result, res);
		check("flags", status[2:0], fl);
	endtask
	// one event pulse
	task automatic pulse(input logic [2:0] e);
		evt = e;
		@(negedge clk_sys_i);
		evt = 3'h0;
		@(negedge clk_sys_i);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// -----------------------------------------
	// scenarios
	// -----------------------------------------
	task automatic t_reset();
		check("status", status, 16'h18);
		check("tmr_ps", tmr_ps, 16'h0);
		check("wdt_ps", wdt_ps, 16'h1);
		$display("test reset done");
	endtask
	// writes, clear at the mirror, flag-setting write
	task automatic t_write();
		mov(7'h03, 8'h27);
		check("status", status, 16'h3f);
		instr(op_clr, 7'h03, 8'h00, 8'h00, 1'b0, 1'b1);
		check("status", status, 16'h1f);
		instr(op_add, 7'h03, 8'h00, 8'he2, 1'b0, 1'b1);
		check("status", status, 16'h1b);
		$display("test status write done");
	endtask
	task automatic t_alu();
		alu(op_add, 8'h08, 8'h08, 8'h10, 3'b010);
		alu(op_xor, 8'h5a, 8'h5a, 8'h00, 3'b110);
		alu(op_add, 8'hff, 8'h01, 8'h00, 3'b111);
		alu(op_sub, 8'h05, 8'h06, 8'hff, 3'b000);
		alu(op_and, 8'h0f, 8'hf0, 8'h00, 3'b100);
		alu(op_sub, 8'h22, 8'h11, 8'h11, 3'b011);
		alu(op_or, 8'h10, 8'h01, 8'h11, 3'b011);
		alu(op_sub, 8'h10, 8'h01, 8'h0f, 3'b001);
		alu(op_sub, 8'h07, 8'h07, 8'h00, 3'b111);
		alu(op_sub, 8'h33, 8'h00, 8'h33, 3'b011);
		$display("test alu done");
	endtask
	// banked writes, file operand, prescaler assignment
	task automatic t_bank();
		mov(7'h20, 8'h5a);
		check("baddr", baddr, 16'h020);
		check("wr", wr, 16'h1);
		mov(7'h03, 8'h20);
		mov(7'h20, 8'ha5);
		check("baddr", baddr, 16'h0a0);
		// let the file write land before the address is presented for reading
		@(negedge clk_sys_i);
		instr(op_add, 7'h20, 8'h00, 8'h00, 1'b0, 1'b0);
		check("result", result, 16'ha5);
		mov(7'h01, 8'hf7);
		check("tmr_ps", tmr_ps, 16'h1);
		check("wdt_ps", wdt_ps, 16'h0);
		mov(7'h01, 8'hff);
		check("wdt_ps", wdt_ps, 16'h1);
		mov(7'h03, 8'h00);
		check("status", status, 16'h18);
		$display("test bank done");
	endtask
	task automatic t_pc();
		mov(7'h0a, 8'hff);
		addr = 7'h0a;
		@(negedge clk_sys_i);
		check("hold", rdata, 16'h1f);
		mov(7'h02, 8'h34);
		check("pc", pc, 16'h1f34);
		// branch takes its upper bits from the holding register
		mov(7'h0a, 8'h05);
		br = 1'b1;
		instr(op_pass, 7'h00, 8'h77, 8'h00, 1'b1, 1'b0);
		br = 1'b0;
		check("pc", pc, 16'h0577);
		$display("test pc done");
	endtask
	task automatic t_cause();
		pulse(3'b100);
		check("pd", status[4:3], 16'h2);
		mov(7'h03, 8'h18);
		check("pd", status[4:3], 16'h2);
		pulse(3'b001);
		check("to", status[4:3], 16'h0);
		pulse(3'b010);
		check("clr", status[4:3], 16'h3);
		$display("test cause done");
	endtask

	// -----------------------------------------
	// main sequence
	// -----------------------------------------
	initial begin
		repeat (4) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		@(negedge clk_sys_i);
		t_reset();
		t_write();
		t_alu();
		t_bank();
		t_pc();
		t_cause();
		results();
	end
endmodule

// [dv/file_ram_model.sv]
// general file memory standing in for the core's data store
`timescale 1ns/1ps
module file_ram_model (
	input  wire logic       clk_sys_i,   // core clock
	input  wire logic [6:0] file_addr_i, // direct address being read
	input  wire logic       bank_i,      // low bank select from status
	input  wire logic [8:0] bank_addr_i, // banked write address
	input  wire logic       write_i,     // general file write strobe
	input  wire logic [7:0] data_i,      // write data
	output logic      [7:0] rd_o         // read data
);
	logic [7:0] mem [0:255]; // two banks of 128 bytes

	// -----------------------------------------
	// read follows the banked address at once
	// -----------------------------------------
	initial begin
		foreach (mem[i])
			mem[i] = 8'h00;
	end
	assign rd_o = mem[{bank_i, file_addr_i}];
	// write takes the byte at the banked address
	always @(posedge clk_sys_i) begin
		if (write_i) begin
			mem[bank_addr_i[7:0]] <= data_i;
		end
	end
endmodule
